// ### rtl/smar_pkg.sv
// Package for the management register bank of the serial combo core.
// Assumes a 25 MHz core clock and a management bus sampled on that clock.
package smar_pkg;

  // Register addresses on the management serial bus
  localparam logic [4:0] REG_CONTROL   = 5'h00;
  localparam logic [4:0] REG_STATUS    = 5'h01;
  localparam logic [4:0] REG_ID_HIGH   = 5'h02;
  localparam logic [4:0] REG_ID_LOW    = 5'h03;
  localparam logic [4:0] REG_ADVERT    = 5'h04;
  localparam logic [4:0] REG_PARTNER   = 5'h05;
  localparam logic [4:0] REG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_LOCAL_NP  = 5'h07;
  localparam logic [4:0] REG_PARTNER_NP = 5'h08;

  // Control word fields
  localparam int CTL_SPEED_LSB  = 13;
  localparam int CTL_AN_ENABLE  = 12;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX     = 8;
  localparam int CTL_COL_TEST   = 7;
  localparam int CTL_SPEED_MSB  = 6;
  localparam logic [15:0] CTL_RESET = 16'h1100;
  localparam logic [15:0] CTL_MASK  = 16'h31c0;

  // Status word fields
  localparam int STS_EXT_STATUS = 8;
  localparam int STS_PRE_SUPP   = 6;
  localparam int STS_AN_DONE    = 5;
  localparam int STS_REM_FAULT  = 4;
  localparam int STS_AN_ABLE    = 3;
  localparam int STS_LINK       = 2;
  localparam int STS_JABBER     = 1;
  localparam int STS_EXT_CAP    = 0;

  // Advertisement and partner ability fields
  localparam int ADV_NEXT_PAGE   = 15;
  localparam logic [15:0] ADV_RESET = 16'h00e0;
  localparam logic [15:0] ADV_MASK  = 16'hb1e0;
  localparam logic [15:0] PAR_MASK  = 16'hf1e1;

  // Expansion word fields
  localparam int EXP_NP_ABLE  = 2;
  localparam int EXP_PAGE_RX  = 1;

  // Next page fields and message codes
  localparam int NP_MORE    = 15;
  localparam int NP_MESSAGE = 13;
  localparam int NP_TOGGLE  = 11;
  localparam logic [10:0] MSG_OVER_1G   = 11'h400;
  localparam logic [10:0] MSG_COPPER    = 11'h410;
  localparam logic [10:0] MSG_REG_WRITE = 11'h411;
  localparam logic [10:0] MSG_REG_READ  = 11'h412;
  localparam logic [10:0] MSG_REG_RESP  = 11'h413;

  // Management frame opcodes and field lengths
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ  = 2'b10;
  localparam logic [3:0] HDR_LAST  = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'hf;

  typedef enum logic [2:0] {
    MSG_NONE      = 3'h0,
    MSG_T_OVER_1G = 3'h1,
    MSG_T_COPPER  = 3'h2,
    MSG_T_WRITE   = 3'h3,
    MSG_T_READ    = 3'h4,
    MSG_T_RESP    = 3'h5,
    MSG_T_OTHER   = 3'h6
  } smar_msg_type;

  typedef struct packed {
    logic       collision_test;
    logic [1:0] speed_sel;
    logic       an_enable;
    logic       full_duplex;
  } smar_ctrl_type;

  typedef struct packed {
    logic        is_next_page;
    logic [15:0] word;
  } smar_page_type;

endpackage : smar_pkg

// ### rtl/smar_regs.sv
// Management register bank with a management serial bus slave and a
// link-side receive port for partner link code words.
// Assumes the management clock is far slower than the core clock and
// that the link clock and core clock are unrelated.
module smar_regs #(
  parameter logic [4:0]  PHY_ADDR  = 5'h00,
  parameter logic [15:0] OUI_MID   = 16'h1234, // Arbitrary value
  parameter logic [5:0]  OUI_TOP   = 6'h15,    // Arbitrary value
  parameter logic [5:0]  MODEL_NUM = 6'h0a,    // Arbitrary value
  parameter logic [3:0]  REV_NUM   = 4'h5      // Arbitrary value
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_mdc,
  input  wire logic                    i_mdio,
  output logic                         o_mdio,
  output logic                         o_mdio_oe,
  input  wire logic                    i_an_complete,
  input  wire logic                    i_remote_fault,
  input  wire logic                    i_link_up,
  input  wire logic                    i_jabber,
  output smar_pkg::smar_ctrl_type      o_ctrl,
  output logic                         o_an_restart,
  output logic [15:0]                  o_advert,
  output logic [15:0]                  o_local_np,
  output logic                         o_local_np_load,
  output logic                         o_partner_np_more,
  output smar_pkg::smar_msg_type       o_partner_msg,
  input  wire logic                    i_link_clk,
  input  wire logic                    i_lnk_valid,
  input  wire smar_pkg::smar_page_type i_lnk_page,
  output logic                         o_lnk_ready
);

  typedef enum logic [2:0] {
    M_IDLE  = 3'h0,
    M_START = 3'h1,
    M_HDR   = 3'h2,
    M_TA    = 3'h3,
    M_DATA  = 3'h4
  } smar_mgmt_state_type;

  smar_mgmt_state_type mstate;
  logic [2:0]          mdc_sync;
  logic [1:0]          mdio_sync;
  logic                mdc_rise;
  logic                mbit;
  logic [3:0]          mcnt;
  logic [10:0]         hdr_sh;
  logic [11:0]         next_hdr;
  logic [15:0]         wr_sh;
  logic [15:0]         rd_sh;
  logic                is_read;
  logic                is_write;
  logic [4:0]          cur_reg;
  logic                hdr_done;
  logic                hdr_match;
  logic                rd_strobe;
  logic [4:0]          rd_addr;
  logic                wr_strobe;
  logic [15:0]         wr_word;
  logic [15:0]         rd_word;

  logic [15:0]         control;
  logic [15:0]         advert;
  logic [15:0]         partner;
  logic [15:0]         local_np;
  logic [15:0]         partner_np;
  logic                np_toggle_ref;
  logic                rf_latch;
  logic                link_latch;
  logic                jab_latch;
  logic                page_rx;

  smar_pkg::smar_page_type lnk_hold;
  logic                lnk_req;
  logic [1:0]          lnk_ack_sync;
  logic [2:0]          req_sync;
  logic                core_ack;
  logic                page_event;

  // Management bus sampling; mdc_sync[0] and mdio_sync[0] feed only the next flop
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mdc_sync  <= 3'h7; // Idle high, so reset release cannot fake a rise
      mdio_sync <= 2'h3;
    end else begin
      mdc_sync  <= {mdc_sync[1:0], i_mdc};
      mdio_sync <= {mdio_sync[0], i_mdio};
    end
  end

  assign mdc_rise  = mdc_sync[1] & ~mdc_sync[2];
  assign mbit      = mdio_sync[1];
  assign next_hdr  = {hdr_sh, mbit};
  assign hdr_done  = mdc_rise && (mstate == M_HDR) && (mcnt == smar_pkg::HDR_LAST);
  assign hdr_match = (next_hdr[9:5] == PHY_ADDR);
  assign rd_strobe = hdr_done && hdr_match && (next_hdr[11:10] == smar_pkg::OP_READ);
  assign rd_addr   = next_hdr[4:0];
  assign wr_word   = {wr_sh[14:0], mbit};
  assign wr_strobe = mdc_rise && (mstate == M_DATA) && is_write &&
                     (mcnt == smar_pkg::DATA_LAST);

  // Frame engine; a lone zero then one starts a frame, preamble optional
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mstate    <= M_IDLE;
      mcnt      <= 4'h0;
      hdr_sh    <= 11'h000;
      wr_sh     <= 16'h0000;
      rd_sh     <= 16'h0000;
      is_read   <= 1'b0;
      is_write  <= 1'b0;
      cur_reg   <= 5'h00;
      o_mdio    <= 1'b1;
      o_mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      unique case (mstate)
        M_IDLE: begin
          if (!mbit) begin
            mstate <= M_START;
          end
        end
        M_START: begin
          if (mbit) begin
            mstate <= M_HDR;
            mcnt   <= 4'h0;
          end
        end
        M_HDR: begin
          hdr_sh <= next_hdr[10:0];
          mcnt   <= mcnt + 4'h1;
          if (mcnt == smar_pkg::HDR_LAST) begin
            mstate   <= M_TA;
            mcnt     <= 4'h0;
            cur_reg  <= next_hdr[4:0];
            is_read  <= rd_strobe;
            is_write <= hdr_match && (next_hdr[11:10] == smar_pkg::OP_WRITE);
            rd_sh    <= rd_word;
          end
        end
        M_TA: begin
          mcnt <= mcnt + 4'h1;
          if (mcnt == 4'h0) begin
            o_mdio_oe <= is_read;
            o_mdio    <= 1'b0;
          end else begin
            mstate <= M_DATA;
            mcnt   <= 4'h0;
            o_mdio <= rd_sh[15];
            rd_sh  <= {rd_sh[14:0], 1'b0};
          end
        end
        M_DATA: begin
          mcnt  <= mcnt + 4'h1;
          wr_sh <= wr_word;
          if (mcnt == smar_pkg::DATA_LAST) begin
            // Released after the master has taken the last bit
            mstate    <= M_IDLE;
            o_mdio_oe <= 1'b0;
            o_mdio    <= 1'b1;
            is_read   <= 1'b0;
            is_write  <= 1'b0;
          end else begin
            o_mdio <= rd_sh[15];
            rd_sh  <= {rd_sh[14:0], 1'b0};
          end
        end
        default: begin
          mstate <= M_IDLE;
        end
      endcase
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_word = 16'h0000;
    unique case (rd_addr)
      smar_pkg::REG_CONTROL: begin
        rd_word = control;
      end
      smar_pkg::REG_STATUS: begin
        rd_word[smar_pkg::STS_EXT_STATUS] = 1'b1;
        rd_word[smar_pkg::STS_PRE_SUPP]   = 1'b1;
        rd_word[smar_pkg::STS_AN_DONE]    = i_an_complete;
        rd_word[smar_pkg::STS_REM_FAULT]  = rf_latch;
        rd_word[smar_pkg::STS_AN_ABLE]    = 1'b1;
        rd_word[smar_pkg::STS_LINK]       = link_latch;
        rd_word[smar_pkg::STS_JABBER]     = jab_latch;
        rd_word[smar_pkg::STS_EXT_CAP]    = 1'b1;
      end
      smar_pkg::REG_ID_HIGH: begin
        rd_word = OUI_MID;
      end
      smar_pkg::REG_ID_LOW: begin
        rd_word = {OUI_TOP, MODEL_NUM, REV_NUM};
      end
      smar_pkg::REG_ADVERT: begin
        rd_word = advert;
      end
      smar_pkg::REG_PARTNER: begin
        rd_word = partner;
      end
      smar_pkg::REG_EXPANSION: begin
        rd_word[smar_pkg::EXP_NP_ABLE] = advert[smar_pkg::ADV_NEXT_PAGE];
        rd_word[smar_pkg::EXP_PAGE_RX] = page_rx;
      end
      smar_pkg::REG_LOCAL_NP: begin
        rd_word = local_np;
      end
      smar_pkg::REG_PARTNER_NP: begin
        rd_word = partner_np;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Control word; restart bit never stored, so it reads back zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      control      <= smar_pkg::CTL_RESET;
      o_an_restart <= 1'b0;
    end else begin
      o_an_restart <= 1'b0;
      if (wr_strobe && cur_reg == smar_pkg::REG_CONTROL) begin
        control      <= wr_word & smar_pkg::CTL_MASK;
        o_an_restart <= wr_word[smar_pkg::CTL_AN_RESTART];
      end
    end
  end

  always_comb begin
    o_ctrl.collision_test = control[smar_pkg::CTL_COL_TEST];
    o_ctrl.speed_sel      = {control[smar_pkg::CTL_SPEED_MSB],
                             control[smar_pkg::CTL_SPEED_LSB]};
    o_ctrl.an_enable      = control[smar_pkg::CTL_AN_ENABLE];
    o_ctrl.full_duplex    = control[smar_pkg::CTL_DUPLEX];
  end

  // Local advertisement; reserved bits held at zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      advert <= smar_pkg::ADV_RESET;
    end else if (wr_strobe && cur_reg == smar_pkg::REG_ADVERT) begin
      advert <= wr_word & smar_pkg::ADV_MASK;
    end
  end

  assign o_advert = advert;

  // Local next page; toggle forced so software cannot break alternation
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      local_np        <= 16'h0000;
      np_toggle_ref   <= 1'b0;
      o_local_np_load <= 1'b0;
    end else begin
      o_local_np_load <= 1'b0;
      if (o_an_restart) begin
        np_toggle_ref <= 1'b0;
      end else if (wr_strobe && cur_reg == smar_pkg::REG_LOCAL_NP) begin
        local_np        <= wr_word;
        local_np[smar_pkg::NP_TOGGLE] <= ~np_toggle_ref;
        np_toggle_ref   <= ~np_toggle_ref;
        o_local_np_load <= 1'b1;
      end
    end
  end

  assign o_local_np = local_np;

  // Latched status bits; an event in the read cycle survives the clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rf_latch   <= 1'b0;
      jab_latch  <= 1'b0;
      link_latch <= 1'b0;
    end else begin
      if (rd_strobe && rd_addr == smar_pkg::REG_STATUS) begin
        rf_latch   <= i_remote_fault;
        jab_latch  <= i_jabber;
        link_latch <= i_link_up;
      end else begin
        rf_latch   <= rf_latch | i_remote_fault;
        jab_latch  <= jab_latch | i_jabber;
        link_latch <= link_latch & i_link_up;
      end
    end
  end

  // Link side: word held stable until the core acknowledges it
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lnk_hold     <= '0;
      lnk_req      <= 1'b0;
      lnk_ack_sync <= 2'h0;
    end else begin
      lnk_ack_sync <= {lnk_ack_sync[0], core_ack};
      if (i_lnk_valid && o_lnk_ready) begin
        lnk_hold <= i_lnk_page;
        lnk_req  <= ~lnk_req;
      end
    end
  end

  assign o_lnk_ready = (lnk_req == lnk_ack_sync[1]);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_sync <= 3'h0;
      core_ack <= 1'b0;
    end else begin
      req_sync <= {req_sync[1:0], lnk_req};
      core_ack <= req_sync[1];
    end
  end

  assign page_event = req_sync[1] ^ req_sync[2];

  // Partner pages and page received flag
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      partner    <= 16'h0000;
      partner_np <= 16'h0000;
      page_rx    <= 1'b0;
    end else begin
      if (page_event && !lnk_hold.is_next_page) begin
        partner <= lnk_hold.word & smar_pkg::PAR_MASK;
      end
      if (page_event && lnk_hold.is_next_page) begin
        partner_np <= lnk_hold.word;
      end else if (wr_strobe && cur_reg == smar_pkg::REG_PARTNER_NP) begin
        partner_np <= wr_word;
      end
      if (page_event) begin
        page_rx <= 1'b1;
      end else if (rd_strobe && rd_addr == smar_pkg::REG_EXPANSION) begin
        page_rx <= 1'b0;
      end
    end
  end

  assign o_partner_np_more = partner_np[smar_pkg::NP_MORE];

  // Message decode only for message pages; registered, one cycle behind the word
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_partner_msg <= smar_pkg::MSG_NONE;
    end else if (!partner_np[smar_pkg::NP_MESSAGE]) begin
      o_partner_msg <= smar_pkg::MSG_NONE;
    end else begin
      unique case (partner_np[10:0])
        smar_pkg::MSG_OVER_1G:   o_partner_msg <= smar_pkg::MSG_T_OVER_1G;
        smar_pkg::MSG_COPPER:    o_partner_msg <= smar_pkg::MSG_T_COPPER;
        smar_pkg::MSG_REG_WRITE: o_partner_msg <= smar_pkg::MSG_T_WRITE;
        smar_pkg::MSG_REG_READ:  o_partner_msg <= smar_pkg::MSG_T_READ;
        smar_pkg::MSG_REG_RESP:  o_partner_msg <= smar_pkg::MSG_T_RESP;
        default:                 o_partner_msg <= smar_pkg::MSG_T_OTHER;
      endcase
    end
  end

endmodule : smar_regs

// ### verif/smar_regs_props.sv
// Concurrent checks on the ports of the management register bank.
// Assumes the management clock stays high for several core cycles.
module smar_regs_props (
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire logic                    i_mdc,
  input wire logic                    o_mdio,
  input wire logic                    o_mdio_oe,
  input wire smar_pkg::smar_ctrl_type o_ctrl,
  input wire logic                    o_an_restart,
  input wire logic [15:0]             o_advert,
  input wire logic [15:0]             o_local_np,
  input wire logic                    o_local_np_load,
  input wire logic                    i_link_clk,
  input wire logic                    i_lnk_valid,
  input wire logic                    o_lnk_ready
);
  ctrl_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> o_ctrl == 5'b00011) else $error("control reset value wrong");
  advert_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> o_advert == 16'h00e0) else $error("advert reset value wrong");
  advert_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_advert & 16'h4e1f) == 16'h0000) else $error("advert reserved bit set");
  ctrl_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $changed(o_ctrl) |-> i_mdc && $past(i_mdc, 3)) else $error("control moved without write");
  restart_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_an_restart |-> i_mdc ##1 !o_an_restart) else $error("restart pulse wrong");
  np_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_local_np_load |=> !o_local_np_load && $stable(o_local_np)) else $error("np load wrong");
  oe_turn_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_mdio_oe) |-> !o_mdio ##1 o_mdio_oe [*8]) else $error("turnaround drive wrong");
  ready_drop_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    i_lnk_valid && o_lnk_ready |=> !o_lnk_ready) else $error("link ready kept high");
  ready_reset_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> o_lnk_ready) else $error("link ready low after reset");
endmodule : smar_regs_props

bind smar_regs smar_regs_props u_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_mdc(i_mdc), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
  .o_ctrl(o_ctrl), .o_an_restart(o_an_restart), .o_advert(o_advert), .o_local_np(o_local_np),
  .o_local_np_load(o_local_np_load), .i_link_clk(i_link_clk), .i_lnk_valid(i_lnk_valid),
  .o_lnk_ready(o_lnk_ready)
);

// ### verif/smar_peer.sv
// Link partner model: hands one link code word per handshake.
// Assumes the caller builds pages; ready only drops after a transfer.
module smar_peer (
  input  wire logic               i_link_clk,
  input  wire logic               i_ready,
  output logic                    o_valid,
  output smar_pkg::smar_page_type o_page
);
  initial begin
    o_valid = 1'b0;
    o_page  = '0;
  end
  task automatic send(input smar_pkg::smar_page_type p);
    @(posedge i_link_clk);
    o_valid <= 1'b1;
    o_page  <= p;
    @(negedge i_link_clk);
    while (i_ready !== 1'b1) @(negedge i_link_clk);
    @(posedge i_link_clk);
    o_valid <= 1'b0;
    o_page  <= ~p; // Released lines do not keep the last word
  endtask : send
endmodule : smar_peer

// ### verif/smar_regs_tb.sv
// Self-checking bench for the management register bank.
// Assumes a pulled-up management data wire and a free-running link clock.
module smar_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wd;
    logic [15:0] exp;
  } smar_row_type;
  localparam logic [15:0] OUI_MID = 16'h0a5c;              // Arbitrary value
  localparam logic [15:0] ID_LOW  = {6'h12, 6'h21, 4'h3}; // Arbitrary value
  logic                    i_clk   = 1'b0;
  logic                    lnk_clk = 1'b0;
  logic                    rst_b   = 1'b0;
  logic                    mdc     = 1'b1;
  logic                    tb_mdio = 1'b1;
  logic                    tb_oe   = 1'b0;
  logic                    an_done = 1'b0;
  logic                    fault   = 1'b0;
  logic                    link    = 1'b1;
  logic                    jab     = 1'b0;
  logic [4:0]              phy     = 5'h00;
  logic                    tog     = 1'b1;
  logic                    mdio_o, mdio_oe, restart, np_load, np_more, lnk_valid, lnk_ready;
  logic [15:0]             advert, local_np, rd;
  smar_pkg::smar_ctrl_type ctrl;
  smar_pkg::smar_msg_type  msg;
  smar_pkg::smar_page_type lnk_page;
  int                      bad_count = 0, n_checks = 0, cycles = 0, restarts = 0, loads = 0;
  wire                     mdio_w = mdio_oe ? mdio_o : (tb_oe ? tb_mdio : 1'b1);
  smar_row_type rows [10] = '{
    '{1'b0, smar_pkg::REG_CONTROL,  16'h0000, 16'h1100},
    '{1'b0, smar_pkg::REG_ADVERT,   16'h0000, 16'h00e0},
    '{1'b0, smar_pkg::REG_ID_HIGH,  16'h0000, OUI_MID},
    '{1'b0, smar_pkg::REG_ID_LOW,   16'h0000, ID_LOW},
    '{1'b1, smar_pkg::REG_LOCAL_NP, 16'ha410, 16'hac10},
    '{1'b1, smar_pkg::REG_LOCAL_NP, 16'h2c11, 16'h2411},
    '{1'b1, smar_pkg::REG_ADVERT,   16'hffff, 16'hb1e0},
    '{1'b1, smar_pkg::REG_ID_HIGH,  16'h0000, OUI_MID},
    '{1'b1, 5'h1f,                  16'hffff, 16'h0000},
    '{1'b1, smar_pkg::REG_CONTROL,  16'hffff, 16'h31c0}
  };
  logic [15:0] pages [7] = '{16'h2400, 16'h2410, 16'h2411, 16'h2412, 16'h2413, 16'ha7ff,
                             16'h0412};
  logic [2:0]  kinds [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};

  smar_regs #(.OUI_MID(OUI_MID), .OUI_TOP(ID_LOW[15:10]), .MODEL_NUM(ID_LOW[9:4]),
              .REV_NUM(ID_LOW[3:0])) dut (
    .i_clk(i_clk), .i_rst_b(rst_b), .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(mdio_o),
    .o_mdio_oe(mdio_oe), .i_an_complete(an_done), .i_remote_fault(fault), .i_link_up(link),
    .i_jabber(jab), .o_ctrl(ctrl), .o_an_restart(restart), .o_advert(advert),
    .o_local_np(local_np), .o_local_np_load(np_load), .o_partner_np_more(np_more),
    .o_partner_msg(msg), .i_link_clk(lnk_clk), .i_lnk_valid(lnk_valid),
    .i_lnk_page(lnk_page), .o_lnk_ready(lnk_ready));
  smar_peer u_peer (.i_link_clk(lnk_clk), .i_ready(lnk_ready), .o_valid(lnk_valid),
                    .o_page(lnk_page));

  always #20 i_clk = ~i_clk;
  initial begin
    #13;
    forever #40 lnk_clk = ~lnk_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (restart === 1'b1) restarts++;
    if (np_load === 1'b1) loads++;
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end

  task automatic results;
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Data changes while the management clock is low, sampled just before it rises
  task automatic bit_cycle(input logic b, input logic drv, output logic s);
    @(posedge i_clk);
    mdc     <= 1'b0;
    tb_mdio <= b;
    tb_oe   <= drv;
    repeat (8) @(posedge i_clk);
    s = mdio_w;
    mdc <= 1'b1;
    repeat (7) @(posedge i_clk);
  endtask : bit_cycle
  // Frame without preamble, one idle bit after it
  task automatic mdio(input logic [1:0] op, input logic [4:0] addr, input logic [15:0] wd,
                      output logic [15:0] rdata);
    logic [31:0] fr;
    logic        s;
    fr = {2'b01, op, phy, addr, 2'b10, wd};
    for (int i = 0; i < 33; i++) begin
      bit_cycle(i < 32 ? fr[31-i] : 1'b1, op != smar_pkg::OP_READ || i < 14 || i > 31, s);
      if (i > 15 && i < 32) rdata[31-i] = s;
    end
  endtask : mdio
  task automatic rdchk(input logic [4:0] addr, input logic [15:0] exp);
    mdio(smar_pkg::OP_READ, addr, 16'h0000, rd);
    check(rd, exp);
  endtask : rdchk

  initial begin
    logic [15:0] p;
    repeat (10) @(posedge i_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (rows[i]) begin
      if (rows[i].wr) mdio(smar_pkg::OP_WRITE, rows[i].addr, rows[i].wd, rd);
      rdchk(rows[i].addr, rows[i].exp);
    end
    check({11'h0, ctrl}, 16'h001f);
    check(local_np, 16'h2411);
    check(advert, 16'hb1e0);
    check(16'(loads), 16'h0002);
    check(16'(restarts), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      mdio(smar_pkg::OP_WRITE, smar_pkg::REG_CONTROL, {2'b00, k[0], 6'h00, k[1], 6'h00}, rd);
      check({11'h0, ctrl}, {11'h0, 1'b0, k[1:0], 2'b00});
    end
    phy = 5'h03;
    mdio(smar_pkg::OP_WRITE, smar_pkg::REG_CONTROL, 16'h1100, rd);
    rdchk(smar_pkg::REG_CONTROL, 16'hffff);
    phy = 5'h00;
    rdchk(smar_pkg::REG_CONTROL, 16'h2040);
    mdio(2'h3, smar_pkg::REG_ADVERT, 16'h0000, rd);
    rdchk(smar_pkg::REG_ADVERT, 16'hb1e0);
    rdchk(smar_pkg::REG_STATUS, 16'h0149);
    rdchk(smar_pkg::REG_STATUS, 16'h014d);
    @(posedge i_clk);
    {fault, jab, link, an_done} <= 4'b1101;
    repeat (4) @(posedge i_clk);
    {fault, jab, link} <= 3'b001;
    rdchk(smar_pkg::REG_STATUS, 16'h017b);
    rdchk(smar_pkg::REG_STATUS, 16'h016d);
    u_peer.send({1'b0, 16'hffff});
    repeat (20) @(posedge i_clk);
    rdchk(smar_pkg::REG_PARTNER, 16'hf1e1);
    rdchk(smar_pkg::REG_EXPANSION, 16'h0006);
    rdchk(smar_pkg::REG_EXPANSION, 16'h0004);
    foreach (pages[i]) begin
      p = pages[i];
      p[11] = tog;
      tog = ~tog;
      u_peer.send({1'b1, p});
      repeat (20) @(posedge i_clk);
      check({13'h0, msg}, {13'h0, kinds[i]});
      check({15'h0, np_more}, {15'h0, p[15]});
    end
    rdchk(smar_pkg::REG_PARTNER_NP, p);
    rdchk(smar_pkg::REG_EXPANSION, 16'h0006);
    @(posedge i_clk);
    rst_b <= 1'b0;
    repeat (10) @(posedge i_clk);
    check({ctrl, advert[10:0]}, {5'b00011, 11'h0e0});
    rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdchk(smar_pkg::REG_STATUS, 16'h0169);
    results();
  end
endmodule : smar_regs_tb
